/* File: rtl/tpm_pkg.sv */
/*
 Package for the telephony port power-mode block: register indices,
 mode codes, reset values and the device power states.
 Assumes both ends and the bench compile it first.
*/
package tpm_pkg;
   // ------------------------------------------------------------
   // Register map of the device control port (word indices)
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_REG_ADDR = 4'h0;
   localparam logic [3:0] IFSEL_REG_ADDR = 4'h1;
   localparam logic [3:0] RSTCNT_REG_ADDR = 4'h2;
   localparam logic [3:0] STATE_REG_ADDR = 4'h3;
   localparam logic [3:0] SCRATCH_REG_ADDR = 4'h4;
   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_SHUTDOWN = 8'h01;
   localparam logic [7:0] IFSEL_INACTIVE = 8'h00;
   localparam logic [7:0] MODE_RESET_VAL = 8'h00;
   localparam logic [7:0] IFSEL_RESET_VAL = 8'h01;
   localparam logic [7:0] SCRATCH_RESET_VAL = 8'h00;
   localparam logic [7:0] RSTCNT_RESET_VAL = 8'h00;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   // Init counter value that ends initialization; init lasts INIT_CYCLES + 1 cycles
   localparam logic [3:0] INIT_CYCLES = 4'h8;
   // ------------------------------------------------------------
   // Host controller command addresses
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_CTRL_ADDR = 4'h0;
   localparam logic [3:0] CMD_ADDR_ADDR = 4'h1;
   localparam logic [3:0] CMD_WDATA_ADDR = 4'h2;
   localparam logic [3:0] CMD_RDATA_ADDR = 4'h3;
   localparam logic [3:0] CMD_STAT_ADDR = 4'h4;
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_READ_BIT = 2;

   typedef enum logic [2:0]
   {
      ST_RESET = 3'b000,
      ST_INIT = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_INACTIVE = 3'b011,
      ST_SHUTDOWN = 3'b100
   } power_state_t;
endpackage

/* File: rtl/tpm_link_if.sv */
/*
 Link between the host controller and the telephony port: the active-high
 module reset pin plus a simple synchronous control port.
 Assumes one common clock for both ends.
*/
`timescale 1ns/10ps
interface tpm_link_if;
   logic module_reset;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic rvalid;

   modport device
   (
      input module_reset,
      input addr,
      input wdata,
      input wr,
      input rd,
      output rdata,
      output rvalid
   );
   modport host
   (
      output module_reset,
      output addr,
      output wdata,
      output wr,
      output rd,
      input rdata,
      input rvalid
   );
endinterface

/* File: rtl/tpm_device.sv */
/*
 Device end: power-state sequencer and register file of the telephony
 port. Control port access is one-cycle strobes; read data and rvalid
 stand in the cycle after the read strobe.
 Assumes the host holds module_reset high until supply is stable.
*/
// Chosen here: the address map and the plain strobed port.
// What this block does, and what it expects of the host
// - Mode write 0x01 in active state enters shutdown sleep
// - Shutdown ignores all register reads and writes
// - Only hard reset leaves shutdown
// - Reset pin high holds reset, unlimited
// - Reset pin low starts initialization
// - Reset release restores factory defaults
// - Reset count increments on every release
// - Host may preset or clear reset count
// - Interface select 0x00 makes port inactive
// - Inactive keeps control port serviced
// - Only another selection write or hard reset leaves inactive
// - Entering inactive reinitializes mode and scratch; selection holds 0x00, reset count kept
// - Host holds reset until power stable
// - Host avoids writes around power removal
// - Host cadences ringing one module at time
`timescale 1ns/10ps
module tpm_device
   import tpm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   tpm_link_if.device LINK,
   output logic [2:0] POWER_STATE_OUT,
   output logic ANALOG_ENABLE_OUT,
   output logic CODEC_POWER_OUT,
   output logic TELECOM_SUPPLY_OUT,
   output logic FUNCTIONS_ENABLE_OUT
);
   power_state_t state;
   power_state_t next_state;
   logic [7:0] module_mode_register;
   logic [7:0] interface_selection_register;
   logic [7:0] scratch;
   logic [7:0] reset_count;
   logic [3:0] init_cnt;
   logic reset_prev;
   logic serviced;
   logic release_evt;
   logic wr_ok;
   logic enter_inactive;
   logic leave_inactive;

   // No register service in reset, init or shutdown
   assign serviced = (state == ST_ACTIVE) || (state == ST_INACTIVE);
   assign wr_ok = LINK.wr && serviced && !LINK.module_reset;
   assign release_evt = reset_prev && !LINK.module_reset;
   assign enter_inactive = wr_ok && state == ST_ACTIVE && LINK.addr == IFSEL_REG_ADDR
      && LINK.wdata == IFSEL_INACTIVE;
   assign leave_inactive = wr_ok && state == ST_INACTIVE && LINK.addr == IFSEL_REG_ADDR
      && LINK.wdata != IFSEL_INACTIVE;

   // ------------------------------------------------------------
   // Power state sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_RESET:
         begin
            if (!LINK.module_reset)
               next_state = ST_INIT;
         end
         ST_INIT:
         begin
            if (init_cnt == INIT_CYCLES)
               next_state = ST_ACTIVE;
         end
         ST_ACTIVE:
         begin
            if (wr_ok && LINK.addr == MODE_REG_ADDR && LINK.wdata == MODE_SHUTDOWN)
               next_state = ST_SHUTDOWN;
            else if (enter_inactive)
               next_state = ST_INACTIVE;
         end
         ST_INACTIVE:
         begin
            if (leave_inactive)
               next_state = ST_ACTIVE;
         end
         ST_SHUTDOWN:
            next_state = ST_SHUTDOWN;
         default:
            next_state = ST_RESET;
      endcase
      if (LINK.module_reset)
         next_state = ST_RESET;
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         state <= ST_RESET;
      else
         state <= next_state;
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         init_cnt <= 4'h0;
      else if (state == ST_INIT)
         init_cnt <= init_cnt + 4'h1;
      else
         init_cnt <= 4'h0;
   end

   // Starts high so power-on release also counts
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         reset_prev <= 1'b1;
      else
         reset_prev <= LINK.module_reset;
   end

   // ------------------------------------------------------------
   // Settings registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         module_mode_register <= MODE_RESET_VAL;
         interface_selection_register <= IFSEL_RESET_VAL;
         scratch <= SCRATCH_RESET_VAL;
      end
      else if (LINK.module_reset || release_evt)
      begin
         module_mode_register <= MODE_RESET_VAL;
         interface_selection_register <= IFSEL_RESET_VAL;
         scratch <= SCRATCH_RESET_VAL;
      end
      else if (enter_inactive)
      begin
         // Selection keeps the 0x00 so the port state reads back truthfully
         module_mode_register <= MODE_RESET_VAL;
         interface_selection_register <= IFSEL_INACTIVE;
         scratch <= SCRATCH_RESET_VAL;
      end
      else if (wr_ok)
      begin
         unique case (LINK.addr)
            MODE_REG_ADDR: module_mode_register <= LINK.wdata;
            IFSEL_REG_ADDR: interface_selection_register <= LINK.wdata;
            SCRATCH_REG_ADDR: scratch <= LINK.wdata;
            default: ;
         endcase
      end
   end

   // Survives release and inactive entry by intent
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         reset_count <= RSTCNT_RESET_VAL;
      else if (release_evt)
         reset_count <= reset_count + 8'h01;
      else if (wr_ok && LINK.addr == RSTCNT_REG_ADDR)
         reset_count <= LINK.wdata;
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         LINK.rdata <= 8'h00;
         LINK.rvalid <= 1'b0;
      end
      else
      begin
         LINK.rvalid <= LINK.rd && serviced && !LINK.module_reset;
         // Same gate as rvalid, so data never stand without an answer
         if (LINK.rd && serviced && !LINK.module_reset)
         begin
            unique case (LINK.addr)
               MODE_REG_ADDR: LINK.rdata <= module_mode_register;
               IFSEL_REG_ADDR: LINK.rdata <= interface_selection_register;
               RSTCNT_REG_ADDR: LINK.rdata <= reset_count;
               STATE_REG_ADDR: LINK.rdata <= {5'h00, state};
               SCRATCH_REG_ADDR: LINK.rdata <= scratch;
               default: LINK.rdata <= UNMAPPED_VAL;
            endcase
         end
         else
            LINK.rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Power outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         POWER_STATE_OUT <= 3'b000;
         ANALOG_ENABLE_OUT <= 1'b0;
         CODEC_POWER_OUT <= 1'b0;
         TELECOM_SUPPLY_OUT <= 1'b0;
         FUNCTIONS_ENABLE_OUT <= 1'b0;
      end
      else
      begin
         POWER_STATE_OUT <= next_state;
         ANALOG_ENABLE_OUT <= next_state == ST_ACTIVE;
         CODEC_POWER_OUT <= next_state == ST_ACTIVE;
         TELECOM_SUPPLY_OUT <= next_state == ST_ACTIVE;
         FUNCTIONS_ENABLE_OUT <= next_state != ST_RESET && next_state != ST_SHUTDOWN;
      end
   end
endmodule

/* File: rtl/tpm_host.sv */
/*
 Host end: drives the module reset pin and relays software register
 accesses onto the control port.
 Assumes software waits for BUSY clear before each new command.
*/
`timescale 1ns/10ps
module tpm_host
   import tpm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   tpm_link_if.host LINK
);
   logic reset_pin;
   logic [3:0] dev_addr;
   logic [7:0] dev_wdata;
   logic [7:0] dev_rdata;
   logic busy;
   logic got_answer;

   assign LINK.module_reset = reset_pin;
   assign LINK.addr = dev_addr;
   assign LINK.wdata = dev_wdata;

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   // Held in reset from power-up until software releases it
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         reset_pin <= 1'b1;
         dev_addr <= 4'h0;
         dev_wdata <= 8'h00;
      end
      else if (WR_IN)
      begin
         unique case (ADDR_IN)
            CMD_CTRL_ADDR: reset_pin <= WDATA_IN[CTRL_RESET_BIT];
            CMD_ADDR_ADDR: dev_addr <= WDATA_IN[3:0];
            CMD_WDATA_ADDR: dev_wdata <= WDATA_IN;
            default: ;
         endcase
      end
   end

   // Command strobes: one cycle each on the port
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         LINK.wr <= 1'b0;
         LINK.rd <= 1'b0;
      end
      else
      begin
         LINK.wr <= WR_IN && ADDR_IN == CMD_CTRL_ADDR && WDATA_IN[CTRL_WRITE_BIT];
         LINK.rd <= WR_IN && ADDR_IN == CMD_CTRL_ADDR && WDATA_IN[CTRL_READ_BIT]
            && !WDATA_IN[CTRL_WRITE_BIT];
      end
   end

   // Unanswered reads (reset, init, shutdown) clear busy after one cycle anyway
   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         busy <= 1'b0;
         got_answer <= 1'b0;
         dev_rdata <= 8'h00;
      end
      else
      begin
         busy <= LINK.rd;
         if (LINK.rvalid)
         begin
            dev_rdata <= LINK.rdata;
            got_answer <= 1'b1;
         end
         else if (LINK.rd)
            got_answer <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         RDATA_OUT <= 8'h00;
      else if (RD_IN)
      begin
         unique case (ADDR_IN)
            CMD_CTRL_ADDR: RDATA_OUT <= {7'h00, reset_pin};
            CMD_ADDR_ADDR: RDATA_OUT <= {4'h0, dev_addr};
            CMD_WDATA_ADDR: RDATA_OUT <= dev_wdata;
            CMD_RDATA_ADDR: RDATA_OUT <= dev_rdata;
            CMD_STAT_ADDR: RDATA_OUT <= {6'h00, got_answer, busy};
            default: RDATA_OUT <= 8'h00;
         endcase
      end
      else
         RDATA_OUT <= 8'h00;
   end
endmodule

/* File: sim/tpm_link_assertions.sv */
/*
 Checker of the host-device link, fed with the interface signals.
 Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/10ps
module tpm_link_assertions
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic module_reset,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   // ------------------------------------------------------------
   // Link timing
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   sequence s_release;
      $fell(module_reset);
   endsequence

   a_answer_needs_read: assert property (rvalid |-> $past(rd))
      else $error("answer without a read");
   a_idle_data_zero: assert property (!rvalid |-> rdata == 8'h00)
      else $error("read data outside an answer");
   a_reset_refuses: assert property (rd && module_reset |=> !rvalid)
      else $error("read answered in reset");
   // Init lasts nine cycles, so a read in its first eight is refused
   a_init_refuses: assert property (s_release ##[0:8] rd |=> !rvalid)
      else $error("read answered during init");
   a_power_on_hold: assert property ($rose(RST_B_IN) |-> module_reset)
      else $error("reset pin not held at power-up");
   a_strobes_apart: assert property (!(wr && rd))
      else $error("write and read strobes together");
   a_wr_single: assert property (wr |=> !wr)
      else $error("write strobe longer than one cycle");
   a_rd_single: assert property (rd |=> !rd)
      else $error("read strobe longer than one cycle");
endmodule

/* File: sim/telephony_port_power_modes_tb_top.sv */
/*
 Bench of the host and device ends joined by the link interface.
 Assumes software waits a fixed four cycles per relayed command.
*/
`timescale 1ns/10ps
module telephony_port_power_modes_tb_top import tpm_pkg::*; ;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] a = 4'h0;
   logic [7:0] d = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdo;
   logic [2:0] st;
   logic an, co, te, fe;
   logic [7:0] v;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   tpm_link_if u_tpm_link_if();
   tpm_host u_tpm_host(.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(a), .WDATA_IN(d),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdo), .LINK(u_tpm_link_if));
   // Single module on the supply, so no ringing overlaps another
   tpm_device u_tpm_device(.CLK_IN(clk), .RST_B_IN(rst_b), .LINK(u_tpm_link_if),
      .POWER_STATE_OUT(st), .ANALOG_ENABLE_OUT(an), .CODEC_POWER_OUT(co),
      .TELECOM_SUPPLY_OUT(te), .FUNCTIONS_ENABLE_OUT(fe));
   tpm_link_assertions u_tpm_link_assertions(.CLK_IN(clk), .RST_B_IN(rst_b),
      .module_reset(u_tpm_link_if.module_reset), .wr(u_tpm_link_if.wr),
      .rd(u_tpm_link_if.rd), .rdata(u_tpm_link_if.rdata), .rvalid(u_tpm_link_if.rvalid));

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Gap cycle after each strobe so no signal is assigned twice at one edge
   task automatic sw_wr(input logic [3:0] ad, input logic [7:0] dt);
      @(posedge clk);
      a <= ad;
      d <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic sw_rd(input logic [3:0] ad, output logic [7:0] dt);
      @(posedge clk);
      a <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its closing edge
      @(posedge clk);
      dt = rdo;
   endtask

   task automatic dev_wr(input logic [3:0] ad, input logic [7:0] dt);
      sw_wr(CMD_ADDR_ADDR, {4'h0, ad});
      sw_wr(CMD_WDATA_ADDR, dt);
      sw_wr(CMD_CTRL_ADDR, 8'h02);
      repeat (4) @(posedge clk);
   endtask

   task automatic dev_chk(input string nm, input logic [3:0] ad, input logic [7:0] exp);
      sw_wr(CMD_ADDR_ADDR, {4'h0, ad});
      sw_wr(CMD_CTRL_ADDR, 8'h04);
      repeat (4) @(posedge clk);
      sw_rd(CMD_RDATA_ADDR, v);
      chk(nm, v, exp);
      // Answer flag set, busy clear: the data are fresh, not stale
      sw_rd(CMD_STAT_ADDR, v);
      chk("answer", v, 8'h02);
   endtask

   // A refused read leaves the answer flag low
   task automatic dev_refused(input string nm, input logic [3:0] ad);
      sw_wr(CMD_ADDR_ADDR, {4'h0, ad});
      sw_wr(CMD_CTRL_ADDR, 8'h04);
      repeat (4) @(posedge clk);
      sw_rd(CMD_STAT_ADDR, v);
      chk(nm, v, 8'h00);
   endtask

   task automatic chk_pw(input power_state_t s, input logic [3:0] o);
      chk("state", {5'h00, st}, {5'h00, s});
      chk("outs", {4'h0, an, co, te, fe}, {4'h0, o});
   endtask

   // Release followed at once by a read that falls inside init
   task automatic hard_reset();
      sw_wr(CMD_CTRL_ADDR, 8'h01);
      repeat (5) @(posedge clk);
      sw_wr(CMD_CTRL_ADDR, 8'h00);
      sw_wr(CMD_CTRL_ADDR, 8'h04);
      repeat (14) @(posedge clk);
      sw_rd(CMD_STAT_ADDR, v);
      chk("init_read", v, 8'h00);
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (30) @(posedge clk);
      chk("pin", {7'h00, u_tpm_link_if.module_reset}, 8'h01);
      chk_pw(ST_RESET, 4'h0);
      sw_rd(CMD_CTRL_ADDR, v);
      chk("pinreg", v, 8'h01);
      sw_wr(CMD_CTRL_ADDR, 8'h05);
      repeat (4) @(posedge clk);
      sw_rd(CMD_RDATA_ADDR, v);
      chk("refused", v, 8'h00);
      sw_rd(4'hF, v);
      chk("unmapped", v, 8'h00);
      sw_wr(CMD_CTRL_ADDR, 8'h00);
      repeat (14) @(posedge clk);
      chk_pw(ST_ACTIVE, 4'hF);
      dev_chk("count", RSTCNT_REG_ADDR, 8'h01);
      dev_chk("ifsel", IFSEL_REG_ADDR, IFSEL_RESET_VAL);
      dev_chk("nomap", 4'h7, UNMAPPED_VAL);
      dev_wr(RSTCNT_REG_ADDR, 8'hFF);
      dev_wr(SCRATCH_REG_ADDR, 8'h5A);
      dev_chk("scratch", SCRATCH_REG_ADDR, 8'h5A);
      hard_reset();
      dev_chk("wrap", RSTCNT_REG_ADDR, 8'h00);
      dev_chk("default", SCRATCH_REG_ADDR, SCRATCH_RESET_VAL);
      dev_wr(SCRATCH_REG_ADDR, 8'h33);
      dev_wr(IFSEL_REG_ADDR, IFSEL_INACTIVE);
      chk_pw(ST_INACTIVE, 4'h1);
      dev_chk("ifsel0", IFSEL_REG_ADDR, IFSEL_INACTIVE);
      dev_chk("stval", STATE_REG_ADDR, {5'h00, ST_INACTIVE});
      dev_chk("cleared", SCRATCH_REG_ADDR, 8'h00);
      dev_wr(SCRATCH_REG_ADDR, 8'h44);
      dev_chk("served", SCRATCH_REG_ADDR, 8'h44);
      chk_pw(ST_INACTIVE, 4'h1);
      dev_wr(IFSEL_REG_ADDR, 8'h02);
      chk_pw(ST_ACTIVE, 4'hF);
      dev_wr(MODE_REG_ADDR, MODE_SHUTDOWN);
      chk_pw(ST_SHUTDOWN, 4'h0);
      dev_wr(IFSEL_REG_ADDR, 8'h02);
      chk_pw(ST_SHUTDOWN, 4'h0);
      dev_refused("asleep", IFSEL_REG_ADDR);
      hard_reset();
      chk_pw(ST_ACTIVE, 4'hF);
      dev_chk("recount", RSTCNT_REG_ADDR, 8'h01);
      dev_chk("mode", MODE_REG_ADDR, MODE_RESET_VAL);
      stop_test();
   end
endmodule
